// *** src/mspi_regs.svh ***
`ifndef MSPI_REGS_SVH
`define MSPI_REGS_SVH

// Byte offsets on the register bus
`define MSPI_OFF_SIZE0        12'h000
`define MSPI_OFF_SIZE1        12'h004
`define MSPI_OFF_PAGE         12'h008
`define MSPI_OFF_CTRL         12'h00C
`define MSPI_OFF_STAT         12'h010

// Size register 0 field positions
`define MSPI_S0_REG_BIT       7
`define MSPI_S0_EEP_LSB       4
`define MSPI_S0_RAM_LSB       0
// Size register 1 field positions
`define MSPI_S1_ROM_LSB       6
`define MSPI_S1_PAG_LSB       0

// Page index reset values for the two integration options
`define MSPI_PAGE_RST_OPEN    6'h00
`define MSPI_PAGE_RST_LOCKED  6'h3C
// RAM position register reset value
`define MSPI_RAMPOS_RST       8'h09

// Partition boundaries per paging code
`define MSPI_BOUND_00         6'h38
`define MSPI_BOUND_01         6'h30
`define MSPI_BOUND_10         6'h20

// Page window address range
`define MSPI_WIN_LO           16'h8000
`define MSPI_WIN_HI           16'hBFFF

// Control register bit positions
`define MSPI_CTRL_ALIGN_BIT   0
`define MSPI_CTRL_UPPER_BIT   1

`endif

// *** src/mspi_pkg.sv ***
package mspi_pkg;

	// Paging partition code
	typedef enum logic [1:0] {
		MSPI_PART_128K = 2'b00,
		MSPI_PART_256K = 2'b01,
		MSPI_PART_512K = 2'b10,
		MSPI_PART_1M   = 2'b11
	} mspi_part_t;

	// Static configuration switches at the core boundary
	typedef struct packed {
		logic       reg_space;
		logic [1:0] eeprom_space;
		logic [2:0] ram_space;
		logic [1:0] program_mem;
		mspi_part_t partition;
	} mspi_switch_t;

	// Far call / return page access
	typedef struct packed {
		logic       wr;
		logic [5:0] wdata;
	} mspi_far_t;

	// RAM placement decoded from the switches
	typedef struct packed {
		logic [15:0] base;
		logic [4:0]  region_kb;
		logic [4:0]  alloc_kb;
		logic [2:0]  pos_bits;
	} mspi_ram_t;

endpackage

// *** src/mspi_ram_map.sv ***
`timescale 1ns/1ps
`include "mspi_regs.svh"

// Decodes the RAM switch code into region, size and reset base
module mspi_ram_map
	import mspi_pkg::*;
(
	input  wire logic [2:0] ram_code,
	input  wire logic       high_align,
	output mspi_ram_t       ram_map
);

	logic [4:0]  alloc_kb;   // Allocated size in KB
	logic [4:0]  region_kb;  // Mappable region in KB
	logic [2:0]  pos_bits;   // Number of position bits used
	logic [15:0] region_bytes;
	logic [15:0] alloc_bytes;
	logic [15:0] pos_base;
	logic [15:0] slack;
	logic [15:0] base_sel;   // Base after alignment

	// Size grows in 2K steps
	assign alloc_kb = {ram_code, 1'b0} + 5'd2;
	// Region is next power of two
	assign region_kb = (ram_code == 3'd0) ? 5'd2 :
		(ram_code == 3'd1) ? 5'd4 :
		(ram_code[2] == 1'b0) ? 5'd8 : 5'd16;
	assign pos_bits = (ram_code == 3'd0) ? 3'd5 :
		(ram_code == 3'd1) ? 3'd4 :
		(ram_code[2] == 1'b0) ? 3'd3 : 3'd2;

	assign region_bytes = {1'b0, region_kb, 10'h000};
	assign alloc_bytes  = {1'b0, alloc_kb, 10'h000};
	// Reset position value masked to the region
	assign pos_base = {`MSPI_RAMPOS_RST, 8'h00} & ~(region_bytes - 16'h0001);
	// Unused space before the RAM when aligned low at reset
	assign slack = region_bytes - alloc_bytes;

	// Low alignment puts RAM at top of region; high alignment at the start
	assign base_sel = high_align ? pos_base : (pos_base + slack);
	// One driver for the whole bundle
	assign ram_map = {base_sel, region_kb, alloc_kb, pos_bits};

endmodule // mspi_ram_map

// *** src/mspi_page_decode.sv ***
`timescale 1ns/1ps
`include "mspi_regs.svh"

// Decides whether the page window access is internal
module mspi_page_decode
	import mspi_pkg::*;
(
	input  wire logic [5:0]  page_index,
	input  wire mspi_part_t  partition,
	input  wire logic [15:0] cpu_addr,
	output logic             win_hit,
	output logic             internal,
	output logic [19:0]      phys_addr
);

	logic [5:0] bound; // Lowest internal page

	// Boundary per partition code
	assign bound = (partition == MSPI_PART_128K) ? `MSPI_BOUND_00 :
		(partition == MSPI_PART_256K) ? `MSPI_BOUND_01 :
		(partition == MSPI_PART_512K) ? `MSPI_BOUND_10 : 6'h00;

	// Window covers 8000..BFFF
	assign win_hit = (cpu_addr >= `MSPI_WIN_LO) && (cpu_addr <= `MSPI_WIN_HI);
	assign internal = win_hit && (page_index >= bound);
	// Page n selects 16K block n
	assign phys_addr = {page_index, cpu_addr[13:0]};

endmodule // mspi_page_decode

// *** src/mspi_top.sv ***
`timescale 1ns/1ps
`include "mspi_regs.svh"

// How it works
// - Size registers read anytime, ignore writes
// - Size register 0 shows register/EEPROM/RAM switches
// - Bit 7: register space 1K or 2K
// - Bits 5:4: EEPROM 0K/2K/4K/8K code
// - RAM code sets size, region, position bits
// - RAM reset base from position value 0x09
// - Small RAM aligned by high-align bit
// - Size register 1: program 7:6, paging 1:0
// - Program code means 0K/16K/48K/64K
// - Upper-only bit gates lower-half program memory for 48K/64K
// - Paging code gives off/on-chip split
// - Pages at or above boundary are internal
// - Six-bit page index, bits 7:6 zero
// - Page n appears in 8000..BFFF window
// - Reset 0x00 open or 0x3C special-only
// - Bus write to page applies next cycle
// - Far call/return path, done within instruction
module mspi_top
	import mspi_pkg::*;
#(
	parameter bit PAGE_LOCKED = 1'b0
)
(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  wire mspi_switch_t switches,
	input  wire logic         special_mode,
	input  wire mspi_far_t    far_req,
	output logic [5:0]        far_rdata,
	input  wire logic [15:0]  cpu_addr,
	output logic              win_hit,
	output logic              win_internal,
	output logic [19:0]       win_phys_addr,
	output logic              lower_prog_enable,
	output logic [15:0]       ram_base
);

	// Reset value of the page index by option
	localparam logic [5:0] PAGE_RST = PAGE_LOCKED ? `MSPI_PAGE_RST_LOCKED
		: `MSPI_PAGE_RST_OPEN;

	logic [5:0]  page_reg;      // Page index in effect
	logic [5:0]  page_next;
	logic        pend_reg;      // Bus write waiting to apply
	logic [5:0]  pend_data_reg; // Value of pending bus write
	logic [1:0]  ctrl_reg;      // Alignment and upper-only bits
	logic [1:0]  ctrl_next;
	logic [31:0] prdata_reg;    // Registered read data
	logic [31:0] prdata_next;
	logic        acc;           // Access phase
	logic        rd_setup;      // Read setup phase
	logic        wr_acc;
	logic        sel_size0;
	logic        sel_size1;
	logic        sel_page;
	logic        sel_ctrl;
	logic        sel_stat;
	logic        mapped;
	logic        page_wr_ok;
	logic [7:0]  size0_val;
	logic [7:0]  size1_val;
	mspi_ram_t   ram_map;

	// Access phase decode
	assign acc    = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign sel_size0 = (paddr == `MSPI_OFF_SIZE0);
	assign sel_size1 = (paddr == `MSPI_OFF_SIZE1);
	assign sel_page  = (paddr == `MSPI_OFF_PAGE);
	assign sel_ctrl  = (paddr == `MSPI_OFF_CTRL);
	assign sel_stat  = (paddr == `MSPI_OFF_STAT);
	assign mapped = sel_size0 | sel_size1 | sel_page | sel_ctrl | sel_stat;

	// Zero-wait slave; unmapped addresses answer with an error
	// Read data is loaded at the setup edge so that it already stands
	// when the access phase completes with pready high
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata  = prdata_reg;

	// Live switch levels, no latching
	assign size0_val = {switches.reg_space, 1'b0, switches.eeprom_space,
		1'b0, switches.ram_space};
	assign size1_val = {switches.program_mem, 4'h0, switches.partition};

	// Locked option permits writes only in special modes
	assign page_wr_ok = !PAGE_LOCKED || special_mode;

	// Read mux; size registers have no write path
	always_comb
	begin
		prdata_next = 32'h0000_0000;
		if (rd_setup)
		begin
			if (sel_size0)
				prdata_next = {24'h00_0000, size0_val};
			else if (sel_size1)
				prdata_next = {24'h00_0000, size1_val};
			else if (sel_page)
				prdata_next = {26'h000_0000, page_reg};
			else if (sel_ctrl)
				prdata_next = {30'h0000_0000, ctrl_reg};
			else if (sel_stat)
				prdata_next = {16'h0000, ram_base};
		end
	end

	// Far write wins over a pending bus write in the same edge
	always_comb
	begin
		page_next = page_reg;
		if (far_req.wr)
			page_next = far_req.wdata;
		else if (pend_reg)
			page_next = pend_data_reg;
	end

	// Control bits writable at any time
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_acc && sel_ctrl)
			ctrl_next = pwdata[1:0];
	end

	// Page index and pending write
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			page_reg      <= PAGE_RST;
			pend_reg      <= 1'b0;
			pend_data_reg <= 6'h00;
		end
		else
		begin
			page_reg      <= page_next;
			pend_reg      <= wr_acc && sel_page && page_wr_ok;
			pend_data_reg <= pwdata[5:0];
		end
	end

	// Control and read data registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_reg   <= 2'b00;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ctrl_reg   <= ctrl_next;
			prdata_reg <= prdata_next;
		end
	end

	// Far path reads without the address bus
	assign far_rdata = page_reg;

	// Lower half accessible for any nonzero program code, unless upper-only set for 48K/64K
	assign lower_prog_enable = (switches.program_mem != 2'b00)
		&& !(switches.program_mem[1] && ctrl_reg[`MSPI_CTRL_UPPER_BIT]);

	// RAM placement
	mspi_ram_map u_ram_map (
		.ram_code   (switches.ram_space),
		.high_align (ctrl_reg[`MSPI_CTRL_ALIGN_BIT]),
		.ram_map    (ram_map)
	);
	assign ram_base = ram_map.base;

	// Page window decode
	mspi_page_decode u_page_decode (
		.page_index (page_reg),
		.partition  (switches.partition),
		.cpu_addr   (cpu_addr),
		.win_hit    (win_hit),
		.internal   (win_internal),
		.phys_addr  (win_phys_addr)
	);

	// Size writes leave the page index and control bits unchanged
	size_ro_a: assert property (@(posedge clk) disable iff (srst)
		(wr_acc && (sel_size0 || sel_size1) && !pend_reg && !far_req.wr)
		|=> page_reg == $past(page_reg) && ctrl_reg == $past(ctrl_reg))
		else $error("size write");

	// Bus write appears exactly one edge later
	sequence bus_page_wr;
		wr_acc && sel_page && page_wr_ok && !far_req.wr;
	endsequence
	page_delay_a: assert property (@(posedge clk) disable iff (srst)
		bus_page_wr ##1 !far_req.wr |=> page_reg == $past(pwdata[5:0], 2))
		else $error("page write timing");
	page_same_a: assert property (@(posedge clk) disable iff (srst)
		bus_page_wr |=> page_reg == $past(page_reg) || $past(far_req.wr))
		else $error("page changed early");

	// Locked option refuses normal-mode bus writes
	page_lock_a: assert property (@(posedge clk) disable iff (srst)
		(PAGE_LOCKED && !special_mode && wr_acc && sel_page) |=> !pend_reg)
		else $error("locked page written");

	// Far write completes by next edge
	far_write_a: assert property (@(posedge clk) disable iff (srst)
		far_req.wr |=> page_reg == $past(far_req.wdata))
		else $error("far write lost");

	// Read access phases of the size and page registers
	sequence size0_rd;
		acc && !pwrite && sel_size0;
	endsequence
	sequence size1_rd;
		acc && !pwrite && sel_size1;
	endsequence
	sequence page_rd;
		acc && !pwrite && sel_page;
	endsequence

	// Reserved read bits are zero while the answer is taken
	size1_zero_a: assert property (@(posedge clk) disable iff (srst)
		size1_rd |-> prdata[5:2] == 4'h0)
		else $error("size1 reserved");
	page_zero_a: assert property (@(posedge clk) disable iff (srst)
		page_rd |-> prdata[7:6] == 2'b00)
		else $error("page reserved");
	ctrl_zero_a: assert property (@(posedge clk) disable iff (srst)
		(acc && !pwrite && sel_ctrl) |-> prdata[31:2] == 30'h0000_0000)
		else $error("ctrl reserved");

	// Read data stands for one access phase only
	read_idle_a: assert property (@(posedge clk) disable iff (srst)
		!rd_setup |=> prdata == 32'h0000_0000)
		else $error("read data stands");

	// Size reads show the switch levels seen at setup
	size0_live_a: assert property (@(posedge clk) disable iff (srst)
		size0_rd |-> prdata[7] == $past(switches.reg_space)
		&& prdata[5:4] == $past(switches.eeprom_space)
		&& prdata[2:0] == $past(switches.ram_space))
		else $error("size0 read");
	size1_live_a: assert property (@(posedge clk) disable iff (srst)
		size1_rd |-> prdata[7:6] == $past(switches.program_mem)
		&& prdata[1:0] == $past(switches.partition))
		else $error("size1 read");

	// Window is the third quarter of the address space
	win_hit_a: assert property (@(posedge clk) disable iff (srst)
		win_hit == (cpu_addr[15:14] == 2'b10))
		else $error("window range");
	win_phys_a: assert property (@(posedge clk) disable iff (srst)
		win_phys_addr[19:14] == page_reg && win_phys_addr[13:0] == cpu_addr[13:0])
		else $error("window page");

	// Internal window only at or above the boundary
	win_part_a: assert property (@(posedge clk) disable iff (srst)
		(win_hit && switches.partition == MSPI_PART_128K)
		|-> win_internal == (page_reg >= 6'h38)) else $error("partition decode");
	win_quarter_a: assert property (@(posedge clk) disable iff (srst)
		(win_hit && switches.partition == MSPI_PART_256K)
		|-> win_internal == (page_reg >= 6'h30)) else $error("quarter decode");
	win_half_a: assert property (@(posedge clk) disable iff (srst)
		(win_hit && switches.partition == MSPI_PART_512K)
		|-> win_internal == (page_reg >= 6'h20)) else $error("half decode");
	win_full_a: assert property (@(posedge clk) disable iff (srst)
		(win_hit && switches.partition == MSPI_PART_1M) |-> win_internal)
		else $error("full decode");
	win_miss_a: assert property (@(posedge clk) disable iff (srst)
		!win_hit |-> !win_internal)
		else $error("internal outside window");

	// Unmapped access answers with an error; an idle bus never does
	bad_addr_a: assert property (@(posedge clk) disable iff (srst)
		(acc && paddr > `MSPI_OFF_STAT) |-> pslverr)
		else $error("unmapped access");
	idle_err_a: assert property (@(posedge clk) disable iff (srst)
		!acc |-> !pslverr)
		else $error("idle error");

	// Upper-only bit blocks lower half for large allocations
	upper_only_a: assert property (@(posedge clk) disable iff (srst)
		(switches.program_mem[1] && ctrl_reg[`MSPI_CTRL_UPPER_BIT]) |-> !lower_prog_enable)
		else $error("upper only");
	upper_open_a: assert property (@(posedge clk) disable iff (srst)
		(switches.program_mem != 2'b00 && !ctrl_reg[`MSPI_CTRL_UPPER_BIT]) |-> lower_prog_enable)
		else $error("lower half blocked");

	// RAM base for a short code in each alignment
	ram_base_a: assert property (@(posedge clk) disable iff (srst)
		(switches.ram_space == 3'd4 && !ctrl_reg[`MSPI_CTRL_ALIGN_BIT]) |-> ram_base == 16'h1800)
		else $error("ram base");
	ram_high_a: assert property (@(posedge clk) disable iff (srst)
		(switches.ram_space == 3'd2 && ctrl_reg[`MSPI_CTRL_ALIGN_BIT]) |-> ram_base == 16'h0000)
		else $error("ram alignment");

endmodule // mspi_top

// *** verification/mspi_far_side.sv ***
`timescale 1ns/1ps

// Stands in for the CPU far path and the integration straps
module mspi_far_side
	import mspi_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         go,
	input  wire logic [5:0]   page,
	input  wire mspi_switch_t cfg,
	output mspi_switch_t      switches,
	output mspi_far_t         far_req
);
	// Straps are plain static levels
	assign switches = cfg;

	// One-cycle far write; idle data toggles so stale data never looks valid
	initial far_req = '0;
	always @(posedge clk)
	begin
		far_req.wr    <= go;
		far_req.wdata <= go ? page : ~far_req.wdata;
	end
endmodule // mspi_far_side

// *** verification/memory_size_and_page_index_test.sv ***
`timescale 1ns/1ps
`include "mspi_regs.svh"

module memory_size_and_page_index_test
	import mspi_pkg::*;
;
	logic         clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic         special_mode = 0, go = 0, pready, pslverr, errv;
	logic         win_hit, win_internal, lower_prog_enable;
	logic [11:0]  paddr = '0;
	logic [31:0]  pwdata = '0, prdata, prdata2, rdv, rdv2;
	logic [5:0]   fpage = '0, far_rdata, snap;
	logic [15:0]  cpu_addr = '0, ram_base;
	logic [19:0]  win_phys_addr;
	mspi_switch_t cfg = '0, switches;
	mspi_far_t    far_req;
	int           fail_count = 0, num_checks = 0, cyc = 0;
	logic [15:0]  bases [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000,
		16'h1800, 16'h1000, 16'h0800, 16'h0000};
	logic [5:0]   bounds [4] = '{6'h38, 6'h30, 6'h20, 6'h00};

	// Free-running clock and a hang guard
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			summarize();
		end
	end

	mspi_far_side model (.clk(clk), .go(go), .page(fpage), .cfg(cfg),
		.switches(switches), .far_req(far_req));
	mspi_top #(.PAGE_LOCKED(1'b0)) dut (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .switches(switches),
		.special_mode(special_mode), .far_req(far_req), .far_rdata(far_rdata),
		.cpu_addr(cpu_addr), .win_hit(win_hit), .win_internal(win_internal),
		.win_phys_addr(win_phys_addr), .lower_prog_enable(lower_prog_enable),
		.ram_base(ram_base));
	// Locked option shares the bus; only its read data is watched
	mspi_top #(.PAGE_LOCKED(1'b1)) dut_lock (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(), .prdata(prdata2), .pslverr(), .switches(switches),
		.special_mode(special_mode), .far_req('0), .far_rdata(),
		.cpu_addr(cpu_addr), .win_hit(), .win_internal(), .win_phys_addr(),
		.lower_prog_enable(), .ram_base());

	// Counts a comparison and reports a mismatch
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			fail_count++;
	endtask

	// One APB transfer; answer and read data taken at the edge with pready high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
		if (pready !== 1'b1)
			fail_count++;
		errv = pslverr;
		rdv = prdata;
		rdv2 = prdata2;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		snap = far_rdata;
		@(posedge clk);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdv, exp);
	endtask

	task summarize();
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		logic [5:0] pg;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`MSPI_OFF_PAGE, 32'h0000_0000);
		chk(rdv2, 32'h0000_003C);
		cfg <= '{1'b1, 2'b10, 3'b101, 2'b11, MSPI_PART_256K};
		@(posedge clk);
		rd(`MSPI_OFF_SIZE0, 32'h0000_00A5);
		apb(1'b1, `MSPI_OFF_SIZE0, 32'hFFFF_FFFF);
		rd(`MSPI_OFF_SIZE0, 32'h0000_00A5);
		apb(1'b1, `MSPI_OFF_SIZE1, 32'h0000_0000);
		rd(`MSPI_OFF_SIZE1, 32'h0000_00C1);
		cfg <= '{1'b0, 2'b01, 3'b010, 2'b10, MSPI_PART_1M};
		@(posedge clk);
		rd(`MSPI_OFF_SIZE0, 32'h0000_0012);
		rd(`MSPI_OFF_SIZE1, 32'h0000_0083);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(errv, 1'b1);
		// Reset base for every RAM code, default alignment
		for (int i = 0; i < 8; i++)
		begin
			cfg.ram_space <= i[2:0];
			@(posedge clk);
			#1 chk(ram_base, bases[i]);
			@(posedge clk);
		end
		chk(lower_prog_enable, 1'b1);
		cfg.ram_space <= 3'b010;
		rd(`MSPI_OFF_STAT, 32'h0000_0800);
		apb(1'b1, `MSPI_OFF_CTRL, 32'h0000_0003);
		@(posedge clk);
		#1 chk(ram_base, 16'h0000);
		chk(lower_prog_enable, 1'b0);
		@(posedge clk);
		rd(`MSPI_OFF_CTRL, 32'h0000_0003);
		apb(1'b1, `MSPI_OFF_PAGE, 32'h0000_00FF);
		chk(snap, 6'h00);
		#1 chk(far_rdata, 6'h3F);
		@(posedge clk);
		rd(`MSPI_OFF_PAGE, 32'h0000_003F);
		chk(rdv2, 32'h0000_003C);
		special_mode <= 1'b1;
		apb(1'b1, `MSPI_OFF_PAGE, 32'h0000_0015);
		rd(`MSPI_OFF_PAGE, 32'h0000_0015);
		chk(rdv2, 32'h0000_0015);
		// Far path sets the page on each side of every partition boundary
		cpu_addr <= 16'hA123;
		for (int k = 0; k < 8; k++)
		begin
			pg = bounds[k / 2] - 6'd1 + 6'(k % 2);
			cfg.partition <= mspi_part_t'(k / 2);
			go <= 1'b1;
			fpage <= pg;
			@(posedge clk);
			go <= 1'b0;
			repeat (2) @(posedge clk);
			#1 chk(far_rdata, pg);
			chk(win_internal, (k % 2 == 1) || (k / 2 == 3));
			chk(win_phys_addr, {pg, 14'h2123});
			chk(win_hit, 1'b1);
			@(posedge clk);
		end
		cpu_addr <= 16'hC000;
		@(posedge clk);
		#1 chk(win_hit, 1'b0);
		summarize();
	end
endmodule // memory_size_and_page_index_test
